/* src/pmr_ctrl.v */
// Power mode and reset controller: run, sleep and idle modes, wake
// sequencing, watchdog, master clear and power-on status capture.
// Assumes CPU strobes and interrupt flags are on ref_clk; the master
// clear pin and clock-fail input are asynchronous. resetn is the
// power-on reset.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.vh"

module pmr_ctrl #(
	parameter [15:0] CSD_CYCLES = `PMR_CSD_CYCLES,
	parameter [15:0] OST_CYCLES = `PMR_OST_CYCLES,
	parameter [15:0] WDT_BASE = `PMR_WDT_BASE
) (
	// Clock, reset, enable
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// CPU core and interrupt logic
	input wire sleep_instr,
	input wire watchdog_clear_instr,
	input wire [7:0] irq_flag,
	input wire clk_fail_in,
	// Clock and reset controls
	output wire cpu_clk_en,
	output wire periph_clk_en,
	output wire [1:0] cpu_clk_src,
	output wire primary_osc_en,
	output wire internal_rc_osc_en,
	output reg vector_branch,
	output reg resume_next,
	output wire core_reset_n,
	// Master clear pin (open drain)
	input wire master_clear_pin_n,
	output wire master_clear_pin_out,
	output wire master_clear_pin_oe
);

localparam [1:0] ST_RUN = 2'h0;
localparam [1:0] ST_SLEEP = 2'h1;
localparam [1:0] ST_IDLE = 2'h2;
localparam [1:0] ST_WAKE = 2'h3;

// ****************************************************************
// Decoding functions
// ****************************************************************
function addr_hit;
	input [11:0] a;
	begin
		addr_hit = (a == `PMR_OFF_CTRL) || (a == `PMR_OFF_IRQ_EN) ||
			(a == `PMR_OFF_STATUS) || (a == `PMR_OFF_RST);
	end
endfunction

function [15:0] post_limit;
	input [3:0] sel;
	begin
		post_limit = (16'h0001 << sel) - 16'h0001;
	end
endfunction

// ****************************************************************
// State
// ****************************************************************
reg idle_on_sleep_reg;
reg [1:0] sys_clock_select_reg;
reg wdt_en_reg;
reg fscm_en_reg;
reg global_irq_enable_reg;
reg ext_clk_reg;
reg ext_pll_reg;
reg [3:0] ps_sel_reg;
reg [7:0] irq_en_reg;
reg por_n_reg;
reg wdt_rst_flag_reg;
reg wdt_wake_flag_reg;
reg osc_startup_status_reg;
reg [1:0] state_reg;
reg [15:0] csd_cnt_reg;
reg [15:0] ost_cnt_reg;
reg [15:0] wdt_cnt_reg;
reg [15:0] wdt_post_reg;
reg wake_irq_reg;
reg wdt_rst_reg;
reg fail1_reg;
reg fail2_reg;
reg fail3_reg;
wire master_clear_pin_hold;

// ****************************************************************
// Master clear filter
// ****************************************************************
pmr_master_clear_pin_filter u_master_clear_pin (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.clk_en(clk_en),
	.master_clear_pin_n(master_clear_pin_n),
	.master_clear_pin_hold(master_clear_pin_hold)
);

// ****************************************************************
// Combinational decode
// ****************************************************************
wire acc = psel & penable;
wire wr = acc & pwrite & addr_hit(paddr);
wire wr_ctrl = wr & (paddr == `PMR_OFF_CTRL);
wire wr_irq = wr & (paddr == `PMR_OFF_IRQ_EN);
wire wr_rst = wr & (paddr == `PMR_OFF_RST);
wire low_pwr = (state_reg == ST_SLEEP) | (state_reg == ST_IDLE);
wire irq_wake = |(irq_flag & irq_en_reg);
wire fail_rise = fail2_reg & ~fail3_reg;
wire wdt_roll = wdt_en_reg & (wdt_cnt_reg == WDT_BASE - 16'h0001);
wire wdt_to = wdt_roll & (wdt_post_reg == post_limit(ps_sel_reg));
wire wdt_clr = (sleep_instr & (state_reg == ST_RUN)) | watchdog_clear_instr |
	(fscm_en_reg & fail_rise) | ~wdt_en_reg;
wire scs_int = sys_clock_select_reg[1];
wire ost_skip = ext_clk_reg | ext_pll_reg;
wire csd_done = (csd_cnt_reg >= CSD_CYCLES - 16'h0001);

// APB answers at once
assign pready = 1'b1;
assign pslverr = acc & ~addr_hit(paddr);

// ****************************************************************
// Clock and reset outputs
// ****************************************************************
// Primary is off when internal RC is selected or in sleep
assign primary_osc_en = (sys_clock_select_reg == `PMR_SCS_PRI) &
	(state_reg != ST_SLEEP) & ~master_clear_pin_hold;
// Until the primary is stable the CPU runs from the internal RC
assign cpu_clk_src = (scs_int | ((sys_clock_select_reg == `PMR_SCS_PRI) &
	~osc_startup_status_reg)) ? `PMR_SCS_INT : sys_clock_select_reg;
// CPU halted in idle, peripherals keep their clock
assign cpu_clk_en = (state_reg == ST_RUN) & ~master_clear_pin_hold;
assign periph_clk_en = (state_reg != ST_SLEEP) & ~master_clear_pin_hold;
assign internal_rc_osc_en = wdt_en_reg | fscm_en_reg |
	((cpu_clk_src == `PMR_SCS_INT) & (state_reg != ST_SLEEP));
assign core_reset_n = ~(master_clear_pin_hold | wdt_rst_reg);
// Pin is input only, never pulled low from inside
assign master_clear_pin_out = 1'b0;
assign master_clear_pin_oe = 1'b0;

// ****************************************************************
// Clock-fail synchroniser
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		fail1_reg <= 1'b0;
		fail2_reg <= 1'b0;
		fail3_reg <= 1'b0;
	end else if (clk_en) begin
		fail1_reg <= clk_fail_in;
		fail2_reg <= fail1_reg;
		fail3_reg <= fail2_reg;
	end
end

// ****************************************************************
// Software registers
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		idle_on_sleep_reg <= 1'b0;
		sys_clock_select_reg <= `PMR_SCS_RST;
		wdt_en_reg <= 1'b0;
		fscm_en_reg <= 1'b0;
		global_irq_enable_reg <= 1'b0;
		ext_clk_reg <= 1'b0;
		ext_pll_reg <= 1'b0;
		ps_sel_reg <= `PMR_PS_RST;
		irq_en_reg <= `PMR_IRQ_EN_RST;
		por_n_reg <= 1'b0; // Power-on clears it
		wdt_rst_flag_reg <= 1'b0;
		wdt_wake_flag_reg <= 1'b0;
	end else if (clk_en) begin
		// Control fields; a wake never writes them
		if (wr_ctrl) begin
			idle_on_sleep_reg <= pwdata[`PMR_CTL_IDLE];
			sys_clock_select_reg <= pwdata[`PMR_CTL_SCS_HI:`PMR_CTL_SCS_LO];
			wdt_en_reg <= pwdata[`PMR_CTL_WDT_EN];
			fscm_en_reg <= pwdata[`PMR_CTL_FSCM_EN];
			global_irq_enable_reg <= pwdata[`PMR_CTL_GIE];
			ext_clk_reg <= pwdata[`PMR_CTL_EXTCLK];
			ext_pll_reg <= pwdata[`PMR_CTL_EXTPLL];
			ps_sel_reg <= pwdata[`PMR_CTL_PS_HI:`PMR_CTL_PS_LO];
		end
		// Reset out of sleep or idle forces internal RC
		if (master_clear_pin_hold & low_pwr)
			sys_clock_select_reg <= `PMR_SCS_INT;
		if (wr_irq)
			irq_en_reg <= pwdata[7:0];
		// Only software sets the power-on bit
		if (wr_rst)
			por_n_reg <= pwdata[`PMR_RST_POR];
		// Sticky flags, write one to clear, set wins
		if (wdt_to & (state_reg == ST_RUN))
			wdt_rst_flag_reg <= 1'b1;
		else if (wr_rst & pwdata[`PMR_RST_WDTRST])
			wdt_rst_flag_reg <= 1'b0;
		if (wdt_to & low_pwr)
			wdt_wake_flag_reg <= 1'b1;
		else if (wr_rst & pwdata[`PMR_RST_WDTWAKE])
			wdt_wake_flag_reg <= 1'b0;
	end
end

// ****************************************************************
// Read data, captured in the setup phase
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		prdata <= 32'h00000000;
	end else if (clk_en & psel & ~penable) begin
		prdata <= 32'h00000000;
		case (paddr)
		`PMR_OFF_CTRL: begin
			prdata[`PMR_CTL_IDLE] <= idle_on_sleep_reg;
			prdata[`PMR_CTL_SCS_HI:`PMR_CTL_SCS_LO] <= sys_clock_select_reg;
			prdata[`PMR_CTL_WDT_EN] <= wdt_en_reg;
			prdata[`PMR_CTL_FSCM_EN] <= fscm_en_reg;
			prdata[`PMR_CTL_GIE] <= global_irq_enable_reg;
			prdata[`PMR_CTL_EXTCLK] <= ext_clk_reg;
			prdata[`PMR_CTL_EXTPLL] <= ext_pll_reg;
			prdata[`PMR_CTL_PS_HI:`PMR_CTL_PS_LO] <= ps_sel_reg;
		end
		`PMR_OFF_IRQ_EN: begin
			prdata[7:0] <= irq_en_reg;
		end
		`PMR_OFF_STATUS: begin
			prdata[`PMR_ST_OSC_STARTUP_STATUS] <= osc_startup_status_reg;
			prdata[`PMR_ST_STATE_HI:`PMR_ST_STATE_LO] <= state_reg;
			prdata[`PMR_ST_MASTER_CLEAR_PIN] <= master_clear_pin_hold;
			prdata[`PMR_ST_PRI_ON] <= primary_osc_en;
			prdata[`PMR_ST_RC_ON] <= internal_rc_osc_en;
		end
		`PMR_OFF_RST: begin
			prdata[`PMR_RST_POR] <= por_n_reg;
			prdata[`PMR_RST_WDTRST] <= wdt_rst_flag_reg;
			prdata[`PMR_RST_WDTWAKE] <= wdt_wake_flag_reg;
		end
		default: begin
			prdata <= 32'h00000000;
		end
		endcase
	end
end

// ****************************************************************
// Oscillator start-up timer
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		osc_startup_status_reg <= 1'b0;
		ost_cnt_reg <= 16'h0000;
	end else if (clk_en) begin
		if (!primary_osc_en) begin
			osc_startup_status_reg <= 1'b0;
			ost_cnt_reg <= 16'h0000;
		end else if (ost_skip) begin
			osc_startup_status_reg <= 1'b1;
		end else if (!osc_startup_status_reg) begin
			if (ost_cnt_reg == OST_CYCLES - 16'h0001)
				osc_startup_status_reg <= 1'b1;
			else
				ost_cnt_reg <= ost_cnt_reg + 16'h0001;
		end
	end
end

// ****************************************************************
// Watchdog counter and postscaler
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		wdt_cnt_reg <= 16'h0000;
		wdt_post_reg <= 16'h0000;
	end else if (clk_en) begin
		if (wdt_clr | master_clear_pin_hold | wdt_to) begin
			wdt_cnt_reg <= 16'h0000;
			wdt_post_reg <= 16'h0000;
		end else if (wdt_roll) begin
			wdt_cnt_reg <= 16'h0000;
			wdt_post_reg <= wdt_post_reg + 16'h0001;
		end else begin
			wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
		end
	end
end

// ****************************************************************
// Power mode state machine
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		state_reg <= ST_RUN;
		csd_cnt_reg <= 16'h0000;
		wake_irq_reg <= 1'b0;
		vector_branch <= 1'b0;
		resume_next <= 1'b0;
		wdt_rst_reg <= 1'b0;
	end else if (clk_en) begin
		vector_branch <= 1'b0;
		resume_next <= 1'b0;
		wdt_rst_reg <= 1'b0;
		if (master_clear_pin_hold) begin
			state_reg <= ST_RUN;
			csd_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
			ST_RUN: begin
				if (wdt_to)
					wdt_rst_reg <= 1'b1;
				else if (sleep_instr)
					state_reg <= idle_on_sleep_reg ? ST_IDLE : ST_SLEEP;
			end
			ST_SLEEP, ST_IDLE: begin
				// Only interrupt, time-out or master clear leave here
				if (irq_wake | wdt_to) begin
					state_reg <= ST_WAKE;
					csd_cnt_reg <= 16'h0000;
					wake_irq_reg <= irq_wake;
				end
			end
			ST_WAKE: begin
				// Fixed start delay before execution
				if (csd_done) begin
					state_reg <= ST_RUN;
					vector_branch <= wake_irq_reg & global_irq_enable_reg;
					resume_next <= ~(wake_irq_reg & global_irq_enable_reg);
				end else begin
					csd_cnt_reg <= csd_cnt_reg + 16'h0001;
				end
			end
			default: begin
				state_reg <= ST_RUN;
			end
			endcase
		end
	end
end

endmodule // pmr_ctrl
`default_nettype wire

/* src/pmr_map.vh */
// Constants of the power mode and reset controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz ref_clk and a 32-bit APB register port.
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PMR_ADDR_W 12
`define PMR_OFF_CTRL 12'h000
`define PMR_OFF_IRQ_EN 12'h004
`define PMR_OFF_STATUS 12'h008
`define PMR_OFF_RST 12'h00C

// ****************************************************************
// Control register fields
// ****************************************************************
`define PMR_CTL_IDLE 0
`define PMR_CTL_SCS_LO 1
`define PMR_CTL_SCS_HI 2
`define PMR_CTL_WDT_EN 3
`define PMR_CTL_FSCM_EN 4
`define PMR_CTL_GIE 5
`define PMR_CTL_EXTCLK 6
`define PMR_CTL_EXTPLL 7
`define PMR_CTL_PS_LO 8
`define PMR_CTL_PS_HI 11

// ****************************************************************
// Status and reset control fields
// ****************************************************************
`define PMR_ST_OSC_STARTUP_STATUS 0
`define PMR_ST_STATE_LO 1
`define PMR_ST_STATE_HI 2
`define PMR_ST_MASTER_CLEAR_PIN 3
`define PMR_ST_PRI_ON 4
`define PMR_ST_RC_ON 5
`define PMR_RST_POR 1
`define PMR_RST_WDTRST 2
`define PMR_RST_WDTWAKE 3

// ****************************************************************
// Clock source encodings and reset values
// ****************************************************************
`define PMR_SCS_PRI 2'h0
`define PMR_SCS_SEC 2'h1
`define PMR_SCS_INT 2'h2
`define PMR_SCS_RST 2'h0
`define PMR_PS_RST 4'h4
`define PMR_IRQ_EN_RST 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define PMR_CSD_CYCLES 16'h0040
`define PMR_OST_CYCLES 16'h0400
`define PMR_WDT_BASE 16'h1000
`define PMR_CLK_NS 10
`define PMR_MASTER_CLEAR_PIN_FILT_NS 200
`define PMR_MASTER_CLEAR_PIN_FILT_CYC ((`PMR_MASTER_CLEAR_PIN_FILT_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)

`endif

/* src/pmr_master_clear_pin_filter.v */
// Synchroniser and noise filter for the master clear pin.
// Assumes the pin is asynchronous to ref_clk and active low.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.vh"

module pmr_master_clear_pin_filter (
	// Clock, reset, enable
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	// Pin and filtered result
	input wire master_clear_pin_n,
	output reg master_clear_pin_hold
);

localparam [31:0] FILT_CYC_W = `PMR_MASTER_CLEAR_PIN_FILT_CYC;
localparam [7:0] FILT_CYC = FILT_CYC_W[7:0];

reg sync1_reg;
reg sync2_reg;
reg [7:0] cnt_reg;

// ****************************************************************
// Two-stage synchroniser, then a stability counter
// ****************************************************************
always @(posedge ref_clk) begin
	if (!resetn) begin
		sync1_reg <= 1'b1;
		sync2_reg <= 1'b1;
		cnt_reg <= 8'h00;
		master_clear_pin_hold <= 1'b0;
	end else if (clk_en) begin
		sync1_reg <= master_clear_pin_n;
		sync2_reg <= sync1_reg;
		// Level must differ from the held state for the whole window
		if (sync2_reg == master_clear_pin_hold) begin
			if (cnt_reg == FILT_CYC - 8'h01) begin
				master_clear_pin_hold <= ~sync2_reg;
				cnt_reg <= 8'h00;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end else begin
			cnt_reg <= 8'h00; // Short pulse dropped
		end
	end
end

endmodule // pmr_master_clear_pin_filter
`default_nettype wire

/* tb/pmr_chk.sv */
// Checker for pmr_ctrl: wake timing, clock gating, master clear.
// Sees only the top ports; shadows software writes seen on APB.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.vh"
module pmr_chk #(
	parameter [15:0] CSD_CYCLES = 16'h0040
) (
	// Clock, reset, APB
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Core side
	input wire logic [7:0] irq_flag,
	input wire logic cpu_clk_en,
	input wire logic primary_osc_en,
	input wire logic internal_rc_osc_en,
	input wire logic vector_branch,
	input wire logic resume_next,
	input wire logic core_reset_n,
	// Master clear pin
	input wire logic master_clear_pin_n,
	input wire logic master_clear_pin_oe
);
	localparam int WAKE_MAX = CSD_CYCLES + 6;
	logic [31:0] ctrl_q;
	logic [7:0] ien_q;
	logic por_q;
	logic [6:0] lo_cnt;
	logic [6:0] hi_cnt;
	logic [15:0] off_cnt;
	logic wr;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	assign wr = psel && penable && pwrite && clk_en;
	// Shadow writes, pin run lengths and cycles with the CPU stopped
	always @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_q <= 32'h0000_0400;
			ien_q <= 8'h00;
			por_q <= 1'b0;
			lo_cnt <= 7'h00;
			hi_cnt <= 7'h00;
			off_cnt <= 16'h0000;
		end else begin
			if (wr && paddr == `PMR_OFF_CTRL)
				ctrl_q <= pwdata;
			if (wr && paddr == `PMR_OFF_IRQ_EN)
				ien_q <= pwdata[7:0];
			if (wr && paddr == `PMR_OFF_RST)
				por_q <= pwdata[`PMR_RST_POR];
			if (clk_en) begin
				lo_cnt <= master_clear_pin_n ? 7'h00 : lo_cnt + {6'h00, ~&lo_cnt};
				hi_cnt <= master_clear_pin_n ? hi_cnt + {6'h00, ~&hi_cnt} : 7'h00;
			end
			off_cnt <= cpu_clk_en ? 16'h0000 : off_cnt + {15'h0000, ~&off_cnt};
		end
	end
	chk_pin_released: assert property (!master_clear_pin_oe)
		else $error("master clear pin enabled for drive");
	chk_rc_kept: assert property (ctrl_q[3] || ctrl_q[4] |-> internal_rc_osc_en)
		else $error("internal RC stopped with watchdog or monitor on");
	chk_pri_stopped: assert property (ctrl_q[2:1] >= 2'h2 |-> !primary_osc_en)
		else $error("primary oscillator on with internal RC selected");
	chk_vector_gie: assert property (vector_branch |-> ctrl_q[5] && !$past(cpu_clk_en))
		else $error("vector branch without global enable");
	chk_wake_bound: assert property (
		!cpu_clk_en && core_reset_n && clk_en && (irq_flag & ien_q) != 8'h00
		|-> ##[1:WAKE_MAX] (vector_branch || resume_next))
		else $error("enabled interrupt did not wake the core");
	chk_wake_delay: assert property ((vector_branch || resume_next) |-> off_cnt > CSD_CYCLES)
		else $error("execution resumed before start delay");
	chk_por_sticky: assert property (
		psel && penable && !pwrite && clk_en && paddr == `PMR_OFF_RST
		|-> prdata[`PMR_RST_POR] == por_q)
		else $error("power-on bit changed by hardware");
	chk_master_clear_pin_hold: assert property (lo_cnt >= 7'h1E |-> !core_reset_n)
		else $error("core not held while pin low");
	chk_master_clear_pin_filter: assert property (
		$fell(core_reset_n) && !master_clear_pin_n |-> lo_cnt >= 7'h14)
		else $error("short pin pulse reached core reset");
	chk_wdt_pulse: assert property (!core_reset_n && hi_cnt >= 7'h28 |=> core_reset_n)
		else $error("internal reset longer than one cycle");
endmodule // pmr_chk
bind pmr_ctrl pmr_chk #(.CSD_CYCLES(CSD_CYCLES)) pmr_chk_inst (
	.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .irq_flag(irq_flag), .cpu_clk_en(cpu_clk_en),
	.primary_osc_en(primary_osc_en), .internal_rc_osc_en(internal_rc_osc_en),
	.vector_branch(vector_branch), .resume_next(resume_next),
	.core_reset_n(core_reset_n), .master_clear_pin_n(master_clear_pin_n),
	.master_clear_pin_oe(master_clear_pin_oe)
);
`default_nettype wire

/* tb/pmr_cpu_model.sv */
// Partner model: CPU instruction strobes, interrupt flags and the
// external master clear pin with its pull-up.
// Assumes its tasks are called by the bench; drives follow ref_clk.
`timescale 1ns/100ps
`default_nettype none
module pmr_cpu_model (
	// Clock
	input wire logic ref_clk,
	// CPU strobes and interrupt flags
	output var logic sleep_instr,
	output var logic watchdog_clear_instr,
	output var logic [7:0] irq_flag,
	// Master clear pin, open drain with pull-up
	output wire logic pin_n
);
	logic pull_low;
	// Pin reads high unless the external switch sinks it
	assign pin_n = pull_low ? 1'b0 : 1'b1;
	initial begin
		sleep_instr = 1'b0;
		watchdog_clear_instr = 1'b0;
		irq_flag = 8'h00;
		pull_low = 1'b0;
	end
	// One-cycle sleep strobe
	task automatic do_sleep();
		@(posedge ref_clk);
		sleep_instr <= 1'b1;
		@(posedge ref_clk);
		sleep_instr <= 1'b0;
	endtask
	// One-cycle watchdog clear strobe
	task automatic do_clear();
		@(posedge ref_clk);
		watchdog_clear_instr <= 1'b1;
		@(posedge ref_clk);
		watchdog_clear_instr <= 1'b0;
	endtask
	task automatic set_irq(input logic [7:0] v);
		@(posedge ref_clk);
		irq_flag <= v;
	endtask
	// Sink the pin for n cycles
	task automatic master_clear_pin(input int n);
		@(posedge ref_clk);
		pull_low <= 1'b1;
		repeat (n) @(posedge ref_clk);
		pull_low <= 1'b0;
	endtask
endmodule // pmr_cpu_model
`default_nettype wire

/* tb/tb.sv */
// Bench for pmr_ctrl: APB, CPU strobes, clock fail and master clear.
// Assumes the design files and pmr_map.vh are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_map.vh"
module tb;
	logic ref_clk, resetn, clk_en, psel, penable, pwrite, clk_fail_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdata, cv;
	logic err, gie, idl;
	logic [1:0] hit, src_at;
	integer seed, bad_count, n_compared, low_cycles, i, k, ib;
	wire [31:0] prdata;
	wire pready, pslverr, sleep_instr, watchdog_clear_instr;
	wire [7:0] irq_flag;
	wire cpu_clk_en, periph_clk_en, primary_osc_en, internal_rc_osc_en;
	wire [1:0] cpu_clk_src;
	wire vector_branch, resume_next, core_reset_n;
	wire master_clear_pin_n, master_clear_pin_out, master_clear_pin_oe;
	logic [31:0] ext_tab [3] = '{32'h440, 32'h480, 32'h401};
	// Device with a short watchdog base, and its partner
	pmr_ctrl #(.WDT_BASE(16'h0008)) pmr_ctrl_inst (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
		.irq_flag(irq_flag), .clk_fail_in(clk_fail_in),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.cpu_clk_src(cpu_clk_src), .primary_osc_en(primary_osc_en),
		.internal_rc_osc_en(internal_rc_osc_en),
		.vector_branch(vector_branch), .resume_next(resume_next),
		.core_reset_n(core_reset_n), .master_clear_pin_n(master_clear_pin_n),
		.master_clear_pin_out(master_clear_pin_out),
		.master_clear_pin_oe(master_clear_pin_oe));
	pmr_cpu_model pmr_cpu_model_inst (.ref_clk(ref_clk),
		.sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
		.irq_flag(irq_flag), .pin_n(master_clear_pin_n));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Count cycles with the core held in reset
	always @(negedge ref_clk) begin
		if (resetn && core_reset_n === 1'b0)
			low_cycles = low_cycles + 1;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expected {vector, resume, clock source} after an interrupt wake
	function automatic logic [3:0] exp_wake(input logic g);
		return {g, ~g, `PMR_SCS_INT};
	endfunction
	task automatic tally_and_finish();
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic give_up();
		bad_count = bad_count + 1;
		$display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
			give_up();
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_src(input logic [1:0] s);
		int n;
		@(negedge ref_clk);
		for (n = 0; n < 2000 && cpu_clk_src !== s; n++)
			@(negedge ref_clk);
		if (n == 2000)
			give_up();
	endtask
	task automatic wait_wake();
		int n;
		@(negedge ref_clk);
		for (n = 0; n < 400 && vector_branch !== 1'b1 && resume_next !== 1'b1; n++)
			@(negedge ref_clk);
		if (n == 400)
			give_up();
		hit = {vector_branch, resume_next};
		src_at = cpu_clk_src;
	endtask
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		clk_fail_in = 1'b0;
		seed = 32'h15698577;
		bad_count = 0;
		n_compared = 0;
		low_cycles = 0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		// Power-on bit, unmapped address, internal RC select
		apb(1'b0, `PMR_OFF_RST, 32'h0);
		check(rdata, 32'h0);
		apb(1'b1, `PMR_OFF_RST, 32'h2);
		apb(1'b0, `PMR_OFF_RST, 32'h0);
		check(rdata, 32'h2);
		apb(1'b0, 12'h010, 32'h0);
		check({err, rdata}, 33'h1_0000_0000);
		wait_src(2'h0);
		apb(1'b1, `PMR_OFF_CTRL, 32'h404);
		apb(1'b0, `PMR_OFF_STATUS, 32'h0);
		check({primary_osc_en, rdata[0]}, 2'b00);
		// Random sleep or idle on internal RC, woken by one interrupt
		for (i = 0; i < 12; i++) begin
			@(posedge ref_clk);
			clk_en <= 1'b0;
			repeat (2) @(posedge ref_clk);
			clk_en <= 1'b1;
			ib = $random(seed) & 7;
			gie = $random(seed);
			idl = $random(seed);
			cv = 32'h400 | {gie, 5'h00} | idl;
			apb(1'b1, `PMR_OFF_IRQ_EN, 32'h1 << ib);
			apb(1'b1, `PMR_OFF_CTRL, cv);
			cv = cv | 32'h4;
			apb(1'b1, `PMR_OFF_CTRL, cv);
			pmr_cpu_model_inst.do_sleep();
			repeat (2) @(negedge ref_clk);
			check({cpu_clk_en, periph_clk_en, internal_rc_osc_en}, {1'b0, idl, idl});
			pmr_cpu_model_inst.set_irq(~(8'h01 << ib));
			repeat (8) @(negedge ref_clk);
			check(cpu_clk_en, 1'b0);
			pmr_cpu_model_inst.set_irq(8'h01 << ib);
			wait_wake();
			check({hit, src_at}, exp_wake(gie));
			pmr_cpu_model_inst.set_irq(8'h00);
			apb(1'b0, `PMR_OFF_CTRL, 32'h0);
			check(rdata, cv);
		end
		// Exits that need no start-up timer
		apb(1'b1, `PMR_OFF_IRQ_EN, 32'h1);
		for (k = 0; k < 3; k++) begin
			apb(1'b1, `PMR_OFF_CTRL, ext_tab[k]);
			wait_src(2'h0);
			pmr_cpu_model_inst.do_sleep();
			repeat (3) @(negedge ref_clk);
			pmr_cpu_model_inst.set_irq(8'h01);
			wait_wake();
			check(src_at, 2'h0);
			pmr_cpu_model_inst.set_irq(8'h00);
		end
		// Watchdog time-out in sleep wakes only
		apb(1'b1, `PMR_OFF_CTRL, 32'h108);
		pmr_cpu_model_inst.do_sleep();
		wait_wake();
		apb(1'b1, `PMR_OFF_CTRL, 32'h400);
		check(hit, 2'b01);
		apb(1'b0, `PMR_OFF_RST, 32'h0);
		check(rdata, 32'hA);
		apb(1'b1, `PMR_OFF_RST, 32'hA);
		// Clear strobes and clock-fail edges hold the watchdog off
		low_cycles = 0;
		for (k = 0; k < 2; k++) begin
			apb(1'b1, `PMR_OFF_CTRL, k ? 32'h118 : 32'h108);
			for (i = 0; i < 15; i++) begin
				if (k) begin
					@(posedge ref_clk);
					clk_fail_in <= 1'b1;
					repeat (2) @(posedge ref_clk);
					clk_fail_in <= 1'b0;
				end else begin
					pmr_cpu_model_inst.do_clear();
				end
				repeat (3) @(posedge ref_clk);
			end
		end
		check(low_cycles, 0);
		// Time-out while running gives a one-cycle internal reset
		for (i = 0; i < 200 && core_reset_n !== 1'b0; i++)
			@(negedge ref_clk);
		if (i == 200)
			give_up();
		check({master_clear_pin_oe, master_clear_pin_out, master_clear_pin_n}, 3'b001);
		apb(1'b1, `PMR_OFF_CTRL, 32'h400);
		check(low_cycles, 1);
		apb(1'b0, `PMR_OFF_RST, 32'h0);
		check(rdata, 32'h6);
		// Short pin pulse ignored; long one in sleep resets to internal RC
		low_cycles = 0;
		pmr_cpu_model_inst.master_clear_pin(8);
		repeat (40) @(negedge ref_clk);
		check(low_cycles, 0);
		pmr_cpu_model_inst.do_sleep();
		repeat (3) @(negedge ref_clk);
		pmr_cpu_model_inst.master_clear_pin(40);
		repeat (40) @(negedge ref_clk);
		check(low_cycles >= 30, 1'b1);
		apb(1'b0, `PMR_OFF_CTRL, 32'h0);
		check(rdata[2:1], 2'h2);
		apb(1'b0, `PMR_OFF_RST, 32'h0);
		check(rdata[1], 1'b1);
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
